// ---- rtl/spi_trig_params.svh ----
// Constants for the serial frame trigger and decode block
`ifndef SPI_TRIG_PARAMS_SVH
`define SPI_TRIG_PARAMS_SVH

`define SPI_WORD_MAX 32
`define SPI_WORD_W 6
`define SPI_CNT_W 16
`define SPI_TS_W 32
`define SPI_SYNC_W 3
`define SPI_PIN_SCLK 0
`define SPI_PIN_CS 1
`define SPI_PIN_DATA 2
`define SPI_CNT_ZERO 16'h0000
`define SPI_CNT_ONE 16'h0001
`define SPI_CNT_MAX 16'hFFFF
`define SPI_TS_ZERO 32'h0000_0000
`define SPI_TS_ONE 32'h0000_0001
`define SPI_POS_ONE 17'h0_0001
`define SPI_WORD_ZERO 32'h0000_0000
`define SPI_LEN_ZERO 6'h00
`define SPI_LEN_ONE 6'h01
`define SPI_LEN_FULL 6'h20

`endif

// ---- rtl/spi_trig_pkg.sv ----
// Types shared by the serial frame trigger and decode block
package spi_trig_pkg;

  // Trigger condition selection
  typedef enum logic [1:0] {
    TRIG_FRAME_START = 2'h0,
    TRIG_FRAME_END = 2'h1,
    TRIG_BIT = 2'h2,
    TRIG_PATTERN = 2'h3
  } trig_mode_t;

  // Frame tracking states, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_ARMED = 3'h2,
    ST_FRAME = 3'h4
  } frame_state_t;

  // Overall state reported per decoded frame
  typedef enum logic [1:0] {
    FRAME_OK = 2'h0,
    FRAME_SHORT_WORD = 2'h1,
    FRAME_EMPTY = 2'h2
  } frame_status_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // One pair of flops per line; first stage feeds only the second
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        meta_q[g] <= 1'b0;
        o_sync[g] <= 1'b0;
      end else begin
        meta_q[g] <= i_async[g];
        o_sync[g] <= meta_q[g];
      end
    end
  end

endmodule // pin_sync

// ---- rtl/spi_frame_trigger_decoder.sv ----
// Serial peripheral bus frame trigger and per-frame decoder
`timescale 1ns/100ps
`include "spi_trig_params.svh"

module spi_frame_trigger_decoder
  import spi_trig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs,
  input wire logic i_data,
  input wire logic i_cs_used,
  input wire logic i_clk_rising,
  input wire logic i_cs_active_high,
  input wire logic i_data_active_high,
  input wire logic [15:0] i_idle_cycles,
  input wire logic [5:0] i_word_size,
  input wire logic i_msb_first,
  input wire logic [1:0] i_trig_mode,
  input wire logic [15:0] i_bit_offset,
  input wire logic [5:0] i_match_length,
  input wire logic [31:0] i_match_value,
  input wire logic [31:0] i_match_care,
  output logic o_in_frame,
  output logic o_frame_start,
  output logic o_frame_end,
  output logic o_trig,
  output logic [31:0] o_trig_time,
  output logic o_word_valid,
  output logic [31:0] o_word_data,
  output logic o_rec_valid,
  output logic [31:0] o_rec_start_time,
  output logic [15:0] o_rec_words,
  output logic [1:0] o_rec_state
);

  // Line level after polarity: 1 means asserted
  function automatic logic act_f(input logic lvl, input logic act_high);
    return act_high ? lvl : ~lvl;
  endfunction

  // Effective pattern length, grown to cover every defined bit
  function automatic logic [5:0] eff_len_f(input logic [5:0] len,
                                           input logic [31:0] care);
    logic [5:0] hi;
    hi = (len > `SPI_LEN_FULL) ? `SPI_LEN_FULL : len;
    for (int i = 0; i < `SPI_WORD_MAX; i++) begin
      if (care[i] && (6'(i + 1) > hi)) begin
        hi = 6'(i + 1);
      end
    end
    return hi;
  endfunction

  logic [2:0] pin_s;
  logic sclk_q;
  frame_state_t st_q;
  frame_state_t st_d;
  logic [15:0] idle_q;
  logic [15:0] bit_cnt_q;
  logic [15:0] bit_cnt_d;
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [31:0] word_q;
  logic [5:0] word_bits_q;
  logic [15:0] words_q;
  logic [31:0] ts_q;
  logic [31:0] start_ts_q;
  logic [31:0] first_bit_ts_q;
  logic [31:0] trig_ts_q;
  logic cs_act;
  logic data_bit;
  logic any_edge;
  logic samp_edge;
  logic start_ev;
  logic end_ev;
  logic idle_done;
  logic bit_ev;
  logic pat_hit;
  logic trig_ev;
  logic [5:0] eff_len;
  logic [5:0] word_size;
  logic [16:0] pat_end;

  // Pins come from another clock domain
  pin_sync #(.W(`SPI_SYNC_W)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_data, i_cs, i_sclk}),
    .o_sync(pin_s)
  );

  // Delayed clock level for edge detection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= pin_s[`SPI_PIN_SCLK];
    end
  end

  // Edge and polarity decode
  assign any_edge = pin_s[`SPI_PIN_SCLK] ^ sclk_q;
  assign samp_edge = any_edge &&
      (pin_s[`SPI_PIN_SCLK] == i_clk_rising);
  assign cs_act = act_f(pin_s[`SPI_PIN_CS], i_cs_active_high);
  assign data_bit = act_f(pin_s[`SPI_PIN_DATA], i_data_active_high);
  assign idle_done = (idle_q >= i_idle_cycles);
  assign word_size = (i_word_size == `SPI_LEN_ZERO) ? `SPI_LEN_ONE :
      ((i_word_size > `SPI_LEN_FULL) ? `SPI_LEN_FULL : i_word_size);

  // Frame boundary decisions
  always_comb begin
    st_d = st_q;
    start_ev = 1'b0;
    end_ev = 1'b0;
    case (st_q)
      ST_WAIT: begin
        if (i_cs_used) begin
          st_d = cs_act ? ST_WAIT : ST_ARMED;
        end else if (idle_done) begin
          st_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (i_cs_used ? cs_act : any_edge) begin
          start_ev = 1'b1;
          st_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (i_cs_used ? !cs_act : (idle_done && !any_edge)) begin
          end_ev = 1'b1;
          st_d = i_cs_used ? ST_ARMED : ST_ARMED;
        end
      end
      default: st_d = ST_WAIT;
    endcase
  end

  // State register and idle gap counter
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= ST_WAIT;
      idle_q <= `SPI_CNT_ZERO;
    end else begin
      st_q <= st_d;
      if (any_edge) begin
        idle_q <= `SPI_CNT_ZERO;
      end else if (idle_q != `SPI_CNT_MAX) begin
        idle_q <= idle_q + `SPI_CNT_ONE;
      end
    end
  end

  // A bit lands on a sampling slope inside or opening a frame
  assign bit_ev = samp_edge &&
      ((st_q == ST_FRAME && !end_ev) || start_ev);
  always_comb begin
    bit_cnt_d = start_ev ? `SPI_CNT_ZERO : bit_cnt_q;
    shift_d = start_ev ? `SPI_WORD_ZERO : shift_q;
    if (bit_ev) begin
      if (bit_cnt_d != `SPI_CNT_MAX) begin
        bit_cnt_d = bit_cnt_d + `SPI_CNT_ONE;
      end
      shift_d = {shift_d[30:0], data_bit};
    end
  end

  // Pattern match at the bit closing offset plus length
  assign eff_len = eff_len_f(i_match_length, i_match_care);
  assign pat_end = {1'b0, i_bit_offset} + {11'h000, eff_len};
  always_comb begin
    pat_hit = bit_ev && (eff_len != `SPI_LEN_ZERO) &&
        ({1'b0, bit_cnt_d} == pat_end);
    for (int i = 0; i < `SPI_WORD_MAX; i++) begin
      // Oldest compared bit sits at eff_len-1
      if ((6'(i) < eff_len) && i_match_care[i] &&
          (shift_d[i] != i_match_value[i])) begin
        pat_hit = 1'b0;
      end
    end
  end

  // Trigger selection
  always_comb begin
    case (trig_mode_t'(i_trig_mode))
      TRIG_FRAME_START: trig_ev = start_ev;
      TRIG_FRAME_END: trig_ev = end_ev;
      TRIG_BIT: trig_ev = bit_ev &&
          ({1'b0, bit_cnt_d} == {1'b0, i_bit_offset} + `SPI_POS_ONE);
      TRIG_PATTERN: trig_ev = pat_hit;
      default: trig_ev = 1'b0;
    endcase
  end

  // Bit position, match history and timestamps
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt_q <= `SPI_CNT_ZERO;
      shift_q <= `SPI_WORD_ZERO;
      ts_q <= `SPI_TS_ZERO;
      start_ts_q <= `SPI_TS_ZERO;
      first_bit_ts_q <= `SPI_TS_ZERO;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      ts_q <= ts_q + `SPI_TS_ONE;
      if (start_ev) begin
        start_ts_q <= ts_q;
      end
      // Start time of the first compared bit, used to place the trigger
      if (bit_ev &&
          ({1'b0, bit_cnt_d} == {1'b0, i_bit_offset} + `SPI_POS_ONE)) begin
        first_bit_ts_q <= ts_q;
      end
    end
  end

  // Trigger pulse and its placed time
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_trig <= 1'b0;
      trig_ts_q <= `SPI_TS_ZERO;
    end else begin
      o_trig <= trig_ev;
      if (trig_ev) begin
        // Pattern is seen only at its last bit; time points at its first
        trig_ts_q <= (trig_mode_t'(i_trig_mode) == TRIG_PATTERN) ?
            first_bit_ts_q : ts_q;
      end
    end
  end
  assign o_trig_time = trig_ts_q;

  // Word assembly in either bit order
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      word_q <= `SPI_WORD_ZERO;
      word_bits_q <= `SPI_LEN_ZERO;
      words_q <= `SPI_CNT_ZERO;
      o_word_valid <= 1'b0;
      o_word_data <= `SPI_WORD_ZERO;
    end else begin
      o_word_valid <= 1'b0;
      if (start_ev) begin
        word_q <= `SPI_WORD_ZERO;
        word_bits_q <= `SPI_LEN_ZERO;
        words_q <= `SPI_CNT_ZERO;
      end
      if (bit_ev) begin
        if (word_bits_q + `SPI_LEN_ONE == word_size || start_ev &&
            word_size == `SPI_LEN_ONE) begin
          o_word_valid <= 1'b1;
          o_word_data <= i_msb_first ? {word_q[30:0], data_bit} :
              (start_ev ? `SPI_WORD_ZERO : word_q) |
              (32'(data_bit) << word_bits_q);
          word_q <= `SPI_WORD_ZERO;
          word_bits_q <= `SPI_LEN_ZERO;
          words_q <= (start_ev ? `SPI_CNT_ZERO : words_q) + `SPI_CNT_ONE;
        end else begin
          word_q <= i_msb_first ?
              {(start_ev ? 31'h0000_0000 : word_q[30:0]), data_bit} :
              (start_ev ? `SPI_WORD_ZERO : word_q) |
              (32'(data_bit) << (start_ev ? `SPI_LEN_ZERO : word_bits_q));
          word_bits_q <= (start_ev ? `SPI_LEN_ZERO : word_bits_q) +
              `SPI_LEN_ONE;
        end
      end
    end
  end

  // Frame record issued at frame end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rec_valid <= 1'b0;
      o_rec_start_time <= `SPI_TS_ZERO;
      o_rec_words <= `SPI_CNT_ZERO;
      o_rec_state <= FRAME_OK;
    end else begin
      o_rec_valid <= end_ev;
      if (end_ev) begin
        // Trigger of this frame may be later than its start: signed
        o_rec_start_time <= start_ts_q -
            (trig_ev ? ts_q : trig_ts_q);
        o_rec_words <= words_q;
        if (word_bits_q != `SPI_LEN_ZERO) begin
          o_rec_state <= FRAME_SHORT_WORD;
        end else if (words_q == `SPI_CNT_ZERO) begin
          o_rec_state <= FRAME_EMPTY;
        end else begin
          o_rec_state <= FRAME_OK;
        end
      end
    end
  end

  // Frame boundary pulses
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frame_start <= 1'b0;
      o_frame_end <= 1'b0;
    end else begin
      o_frame_start <= start_ev;
      o_frame_end <= end_ev;
    end
  end
  assign o_in_frame = (st_q == ST_FRAME);

endmodule // spi_frame_trigger_decoder

// ---- tb/spi_trig_properties.sv ----
// Checker of frame and trigger timing at the decoder ports
`timescale 1ns/100ps
module spi_trig_properties
  import spi_trig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs,
  input wire logic i_cs_used,
  input wire logic i_cs_active_high,
  input wire logic [1:0] i_trig_mode,
  input wire logic o_in_frame,
  input wire logic o_frame_start,
  input wire logic o_frame_end,
  input wire logic o_trig,
  input wire logic o_rec_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Select level with its polarity folded in; polarity held between frames
  logic sel;
  assign sel = i_cs == i_cs_active_high;

  // Pin path is two sync flops plus the registered frame pulse
  sel_start_a: assert property (
    $rose(sel) && i_cs_used && !o_in_frame |-> ##[2:5] o_frame_start)
    else $error("select active without frame start");
  sel_end_a: assert property (
    $fell(sel) && i_cs_used && o_in_frame |-> ##[2:5] o_frame_end)
    else $error("select inactive without frame end");
  start_in_frame_a: assert property (
    o_frame_start |-> o_in_frame)
    else $error("frame start outside frame");
  end_record_a: assert property (
    o_frame_end |-> !o_in_frame && o_rec_valid)
    else $error("frame end without record");
  start_end_apart_a: assert property (
    o_frame_start |-> !o_frame_end)
    else $error("start and end together");
  start_trig_a: assert property (
    o_frame_start && i_trig_mode == TRIG_FRAME_START |-> o_trig)
    else $error("no trigger at frame start");
  end_trig_a: assert property (
    o_frame_end && i_trig_mode == TRIG_FRAME_END |-> o_trig)
    else $error("no trigger at frame end");
  bit_trig_a: assert property (
    o_trig && i_trig_mode == TRIG_BIT |-> o_in_frame)
    else $error("bit trigger outside frame");
endmodule // spi_trig_properties

// ---- tb/spi_bus_model.sv ----
// Observed bus master driving select, clock and one data line
`timescale 1ns/100ps
module spi_bus_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_data
);
  // Clock rests at its idle level and select inactive between frames
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_data = 1'h0;
  end

  // Sends n bits MSB first at a 400 ns clock period
  task automatic send(input int n, input logic [31:0] v, input bit sel);
    if (sel)
      o_cs_n = 1'h0;
    #437;
    for (int i = n - 1; i >= 0; i--) begin
      o_data = v[i];
      #200 o_sclk = ~o_sclk;
      #200 o_sclk = ~o_sclk;
    end
    #200;
    if (sel)
      o_cs_n = 1'h1;
    o_data = ~o_data; // Released line shows no stale bit
  endtask

  // Sets the idle clock level; the leading slope is then its inverse
  task automatic rest(input logic lvl);
    o_sclk = lvl;
  endtask
endmodule // spi_bus_model

// ---- tb/spi_frame_trigger_decoder_tb.sv ----
// Self-checking bench for the serial frame trigger decoder
`timescale 1ns/100ps
module spi_frame_trigger_decoder_tb;
  import spi_trig_pkg::*;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic sclk, cs_n, sd, cs_used, msb, in_f, fs, fe, trig, wv, rv;
  logic [15:0] offset, rw;
  logic [5:0] ws, mlen;
  logic [1:0] mode, rs;
  logic [31:0] mval, mcare, wd, pv;
  logic [31:0] qw[$];
  logic [31:0] qr[$];
  logic [7:0] trigs = 8'h00;
  logic [31:0] tt, rt;
  logic [31:0] cyc = 32'h0;
  logic [31:0] scyc = 32'h0;
  logic [31:0] tcyc = 32'h0;
  logic rise = 1'h1;
  logic csah = 1'h0;
  logic dah = 1'h1;
  // First pattern bit lies seven bus bits of eight clocks before the last
  localparam logic [31:0] PAT_BACK = 32'h38;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 i_clk = ~i_clk;

  // Clocks since reset, the bench's own time base for trigger times
  always @(posedge i_clk)
    cyc <= i_sys_rst ? 32'h0 : cyc + 32'h1;

  spi_bus_model bus (.o_sclk(sclk), .o_cs_n(cs_n), .o_data(sd));
  spi_frame_trigger_decoder dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sclk(sclk), .i_cs(cs_n ^ csah), .i_data(sd), .i_cs_used(cs_used),
    .i_clk_rising(rise), .i_cs_active_high(csah),
    .i_data_active_high(dah), .i_idle_cycles(16'h0018),
    .i_word_size(ws), .i_msb_first(msb), .i_trig_mode(mode),
    .i_bit_offset(offset), .i_match_length(mlen), .i_match_value(mval),
    .i_match_care(mcare), .o_in_frame(in_f), .o_frame_start(fs),
    .o_frame_end(fe), .o_trig(trig), .o_trig_time(tt), .o_word_valid(wv),
    .o_word_data(wd), .o_rec_valid(rv), .o_rec_start_time(rt),
    .o_rec_words(rw), .o_rec_state(rs));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cfg(input logic c, input logic [1:0] m,
      input logic [15:0] o, input logic [5:0] s, input logic b);
    @(posedge i_clk);
    #2;
    cs_used = c;
    mode = m;
    offset = o;
    ws = s;
    msb = b;
  endtask

  // Notes the expected words and record, then plays the frame
  task automatic frame(input int n, input logic [31:0] v, input logic [7:0] t);
    logic [31:0] w;
    logic [31:0] p;
    int k;
    k = 0;
    p = dah ? v : ~v; // Low-active data goes out inverted on the pin
    w = 32'h0;
    for (int j = 1; j <= n; j++) begin
      if (msb)
        w = {w[30:0], v[n - j]};
      else
        w[k] = v[n - j];
      k++;
      if (k == ws) begin
        qw.push_back(w);
        w = 32'h0;
        k = 0;
      end
    end
    qr.push_back({6'h00, 16'(n / ws), (k != 0) ? 2'h1 : (n < ws) ? 2'h2 :
      2'h0, t});
    if (cs_used)
      bus.send(n, p, 1'h1);
    else begin
      // Two bursts closer than the idle gap make one frame
      bus.send(n / 2, p >> (n / 2), 1'h0);
      bus.send(n / 2, p, 1'h0);
    end
    #3000;
  endtask

  // Takes the oldest note whenever the decoder shows a word or a record
  always @(negedge i_clk) begin
    if (i_sys_rst) begin
      trigs = 8'h00;
      scyc = 32'h0;
      tcyc = 32'h0;
    end else begin
      if (fs !== 1'h0)
        scyc = cyc - 32'h1;
      if (trig !== 1'h0) begin
        trigs++;
        tcyc = cyc - 32'h1 - ((mode == TRIG_PATTERN) ? PAT_BACK : 32'h0);
        check(tt, tcyc);
      end
      if (wv !== 1'h0)
        check(wd, qw.pop_front());
      if (rv !== 1'h0) begin
        check({6'h00, rw, rs, trigs}, qr.pop_front());
        check(rt, scyc - tcyc);
        trigs = 8'h00;
      end
    end
  end

  initial begin
    #500000;
    miscompares++;
    close_out();
  end

  initial begin
    {cs_used, msb, mode, offset, ws} = '0;
    mlen = 6'h04;
    mcare = 32'h0000_00F3;
    mval = 32'h0;
    void'($urandom(32'h3CBBEBF4));
    repeat (6) @(posedge i_clk);
    #2 i_sys_rst = 1'h0;
    repeat (10) @(posedge i_clk);
    cfg(1'h1, TRIG_FRAME_START, 16'h0, 6'h08, 1'h1);
    frame(16, $urandom, 8'h01);
    frame(6, $urandom, 8'h01);
    cfg(1'h1, TRIG_FRAME_END, 16'h0, 6'h05, 1'h0);
    frame(12, $urandom, 8'h01);
    cfg(1'h1, TRIG_BIT, 16'h000F, 6'h08, 1'h1);
    frame(16, $urandom, 8'h01);
    cfg(1'h1, TRIG_BIT, 16'h0010, 6'h08, 1'h1);
    frame(16, $urandom, 8'h00);
    pv = $urandom;
    mval = {24'h0, pv[12:5]};
    cfg(1'h1, TRIG_PATTERN, 16'h0003, 6'h08, 1'h1);
    frame(16, pv, 8'h01);
    frame(16, pv ^ 32'h0000_1000, 8'h00);
    frame(16, pv ^ 32'h0000_0080, 8'h01);
    @(posedge i_clk);
    #2 i_sys_rst = 1'h1;
    repeat (2) @(posedge i_clk);
    #2 i_sys_rst = 1'h0;
    cfg(1'h0, TRIG_FRAME_START, 16'h0, 6'h08, 1'h1);
    repeat (30) @(posedge i_clk);
    frame(16, $urandom, 8'h01);
    frame(16, $urandom, 8'h01);
    // Inverted select and data lines, bits on the falling clock slope
    @(posedge i_clk);
    #2 {rise, csah, dah} = 3'h2;
    repeat (4) @(posedge i_clk);
    cfg(1'h1, TRIG_FRAME_START, 16'h0, 6'h08, 1'h0);
    repeat (4) @(posedge i_clk);
    #2 bus.rest(1'h1);
    repeat (4) @(posedge i_clk);
    #2;
    frame(16, $urandom, 8'h01);
    frame(0, 32'h0, 8'h01);
    check(32'(qw.size()), 32'h0);
    check(32'(qr.size()), 32'h0);
    close_out();
  end
endmodule // spi_frame_trigger_decoder_tb

bind spi_frame_trigger_decoder spi_trig_properties chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_cs(i_cs), .i_cs_used(i_cs_used),
  .i_cs_active_high(i_cs_active_high), .i_trig_mode(i_trig_mode),
  .o_in_frame(o_in_frame), .o_frame_start(o_frame_start),
  .o_frame_end(o_frame_end), .o_trig(o_trig), .o_rec_valid(o_rec_valid));
